// *** include/qp_pkg.sv ***
// package of constants, types and helpers for the quad pot register bank
package qp_pkg;

    localparam int unsigned qp_locations = 16;
    localparam int unsigned qp_addr_width = 4;
    localparam int unsigned qp_word_width = 9;
    localparam int unsigned qp_pots = 4;

    typedef logic [qp_addr_width-1:0] qp_addr_type;
    typedef logic [qp_word_width-1:0] qp_word_type;
    typedef logic [qp_locations-1:0][qp_word_width-1:0] qp_image_type;

    // register offsets
    localparam qp_addr_type qp_wiper0_position_addr = 4'h0;
    localparam qp_addr_type qp_wiper1_position_addr = 4'h1;
    localparam qp_addr_type qp_terminal_control_pots01_addr = 4'h4;
    localparam qp_addr_type qp_wiper2_position_addr = 4'h6;
    localparam qp_addr_type qp_wiper3_position_addr = 4'h7;
    localparam qp_addr_type qp_terminal_control_pots23_addr = 4'ha;

    // reset values and wiper scale limits
    localparam qp_word_type qp_wiper_reset_8bit = 9'h080;
    localparam qp_word_type qp_wiper_reset_7bit = 9'h040;
    localparam qp_word_type qp_terminal_control_reset = 9'h1ff;
    localparam qp_word_type qp_full_scale_8bit = 9'h100;
    localparam qp_word_type qp_full_scale_7bit = 9'h080;
    localparam qp_word_type qp_zero_scale = 9'h000;
    localparam qp_word_type qp_step = 9'h001;

    // terminal control field positions, upper pot in bits 7..4, lower pot in bits 3..0
    localparam int unsigned qp_reserved_top_bit = 8;
    localparam int unsigned qp_upper_shutdown_release = 7;
    localparam int unsigned qp_upper_end_a_connect = 6;
    localparam int unsigned qp_upper_wiper_connect = 5;
    localparam int unsigned qp_upper_end_b_connect = 4;
    localparam int unsigned qp_lower_shutdown_release = 3;
    localparam int unsigned qp_lower_end_a_connect = 2;
    localparam int unsigned qp_lower_wiper_connect = 1;
    localparam int unsigned qp_lower_end_b_connect = 0;

    typedef enum logic [1:0] {
        qp_op_write = 2'h0,
        qp_op_increment = 2'h1,
        qp_op_decrement = 2'h2,
        qp_op_read = 2'h3
    } qp_op_type;

    typedef enum logic [1:0] {
        qp_hvc_low = 2'h0,
        qp_hvc_normal_high = 2'h1,
        qp_hvc_high_voltage = 2'h3
    } qp_hvc_type;

    typedef enum logic [1:0] {
        qp_st_idle = 2'h0,
        qp_st_read = 2'h1,
        qp_st_modify = 2'h3
    } qp_state_type;

    typedef struct packed {
        qp_image_type words;
        qp_word_type rdata;
    } qp_mem_state_type;

    typedef struct packed {
        qp_state_type state;
        logic error;
        logic hvc_high_seen;
        logic pending_decrement;
        qp_addr_type pending_addr;
        logic [1:0][qp_word_width-1:0] applied;
    } qp_ctrl_state_type;

    function automatic logic qp_is_wiper(input qp_addr_type addr);
        return addr == qp_wiper0_position_addr || addr == qp_wiper1_position_addr ||
               addr == qp_wiper2_position_addr || addr == qp_wiper3_position_addr;
    endfunction : qp_is_wiper

    function automatic logic qp_is_tcon(input qp_addr_type addr);
        return addr == qp_terminal_control_pots01_addr || addr == qp_terminal_control_pots23_addr;
    endfunction : qp_is_tcon

    function automatic qp_word_type qp_wiper_reset(input logic wide);
        return wide ? qp_wiper_reset_8bit : qp_wiper_reset_7bit;
    endfunction : qp_wiper_reset

    function automatic qp_word_type qp_full_scale(input logic wide);
        return wide ? qp_full_scale_8bit : qp_full_scale_7bit;
    endfunction : qp_full_scale

    // power-on image; reserved locations hold zero
    function automatic qp_image_type qp_reset_image(input logic wide);
        qp_image_type image;
        image = '0;
        for (int i = 0; i < qp_locations; i++) begin
            if (qp_is_wiper(qp_addr_type'(i))) begin
                image[i] = qp_wiper_reset(wide);
            end else if (qp_is_tcon(qp_addr_type'(i))) begin
                image[i] = qp_terminal_control_reset;
            end
        end
        return image;
    endfunction : qp_reset_image

endpackage : qp_pkg

// *** include/qp_mem_if.sv ***
// interface between the command controller and the register memory
`timescale 1ns/1ps
interface qp_mem_if;
    import qp_pkg::*;
    logic clear;
    logic en;
    logic we;
    qp_addr_type addr;
    qp_word_type wdata;
    qp_word_type rdata;
    qp_image_type words;
    modport ctrl (output clear, output en, output we, output addr, output wdata, input rdata, input words);
    modport mem (input clear, input en, input we, input addr, input wdata, output rdata, output words);
endinterface : qp_mem_if

// *** rtl/qp_mem.sv ***
// sixteen by nine volatile register memory with registered read data
`timescale 1ns/1ps
module qp_mem #(
    parameter logic wide_wiper = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    qp_mem_if.mem port
);
    import qp_pkg::*;

    localparam qp_image_type reset_image = qp_reset_image(wide_wiper);

    qp_mem_state_type r;
    qp_mem_state_type next_r;

    always_comb begin
        next_r = r;
        if (port.clear) begin
            next_r.words = reset_image; // [RULE13]
            next_r.rdata = '0;
        end else if (port.en) begin
            if (port.we) begin
                next_r.words[port.addr] = port.wdata;
            end
            next_r.rdata = r.words[port.addr];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= '{words: reset_image, rdata: '0}; // [RULE1] [RULE3] [RULE9]
        end else begin
            r <= next_r;
        end
    end

    assign port.rdata = r.rdata;
    assign port.words = r.words;

endmodule : qp_mem

// *** rtl/qp_regmap.sv ***
// command controller of the quad pot volatile register bank
`timescale 1ns/1ps
// Operation
// RULE1 - sixteen volatile nine-bit locations form the register space
// RULE2 - wipers at 00h 01h 06h 07h, terminal controls at 04h 0Ah, rest reserved
// RULE3 - wipers reset to mid-scale, 80h or 40h by resolution
// RULE4 - illegal command or reserved address enters the error condition
// RULE5 - error clears only after pin goes normal high then back active
// RULE6 - each terminal control register holds four control bits per pot
// RULE7 - each pot terminal connects through its own control bit
// RULE8 - terminal control values reach the network when the command completes
// RULE9 - terminal control registers reset to 1FFh, all terminals connected
// RULE10 - host detects reset events and rewrites terminal control values
// RULE11 - bit 8 reads one; bits 7..4 upper pot, 3..0 lower pot
// RULE12 - cleared release forces shutdown; set connect bit connects terminal
// RULE13 - reset pin low holds defaults and disables the command port
// RULE14 - internal reset while detector active or reset pin low
module qp_regmap #(
    parameter logic wide_wiper = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic reset_pin_n,
    input wire qp_pkg::qp_hvc_type high_voltage_command_pin,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire qp_pkg::qp_op_type cmd_op,
    input wire qp_pkg::qp_addr_type cmd_addr,
    input wire qp_pkg::qp_word_type cmd_wdata,
    input wire logic cmd_complete,
    output logic rsp_valid,
    output qp_pkg::qp_word_type rsp_data,
    output logic error_active,
    output logic [3:0][8:0] wiper_position,
    output logic [3:0] pot_shutdown_forced,
    output logic [3:0] pot_end_a_connect,
    output logic [3:0] pot_wiper_connect,
    output logic [3:0] pot_end_b_connect
);
    import qp_pkg::*;

    localparam qp_ctrl_state_type reset_state = '{
        state: qp_st_idle,
        error: 1'b0,
        hvc_high_seen: 1'b0,
        pending_decrement: 1'b0,
        pending_addr: '0,
        applied: {qp_terminal_control_reset, qp_terminal_control_reset}
    };

    qp_mem_if mem_bus ();

    qp_ctrl_state_type r;
    qp_ctrl_state_type next_r;
    logic pin_hold;
    logic accept;
    logic cmd_legal;
    logic error_set;
    logic error_clear;
    qp_word_type modified;

    qp_mem #(
        .wide_wiper(wide_wiper)
    ) u_mem (
        .clk(clk),
        .reset(reset),
        .port(mem_bus.mem)
    );

    // detector reset acts asynchronously, the pin acts as a synchronous clear
    assign pin_hold = ~reset_pin_n; // [RULE14]

    // the port is closed while the reset pin is low, in error and while a read or modify is in flight
    assign cmd_ready = ~pin_hold && ~r.error && r.state == qp_st_idle; // [RULE13]
    assign accept = cmd_valid && cmd_ready;

    always_comb begin
        cmd_legal = 1'b0;
        if (qp_is_wiper(cmd_addr)) begin
            cmd_legal = 1'b1; // [RULE2]
        end else if (qp_is_tcon(cmd_addr)) begin
            cmd_legal = cmd_op == qp_op_read || cmd_op == qp_op_write; // [RULE4]
        end
    end

    // saturating step; the pot cannot wrap past either end of the ladder
    always_comb begin
        modified = mem_bus.rdata;
        if (r.pending_decrement) begin
            if (mem_bus.rdata > qp_zero_scale) begin
                modified = mem_bus.rdata - qp_step;
            end
        end else if (mem_bus.rdata < qp_full_scale(wide_wiper)) begin
            modified = mem_bus.rdata + qp_step;
        end
    end

    assign error_set = accept && ~cmd_legal; // [RULE4]
    assign error_clear = r.error && r.hvc_high_seen && high_voltage_command_pin != qp_hvc_normal_high; // [RULE5]

    always_comb begin
        next_r = r;
        mem_bus.clear = pin_hold;
        mem_bus.en = 1'b0;
        mem_bus.we = 1'b0;
        mem_bus.addr = cmd_addr;
        mem_bus.wdata = cmd_wdata;
        if (pin_hold) begin
            next_r = reset_state; // [RULE13]
        end else begin
            if (r.error && high_voltage_command_pin == qp_hvc_normal_high) begin
                next_r.hvc_high_seen = 1'b1; // [RULE5]
            end
            next_r.error = error_set || (r.error && ~error_clear);
            if (error_clear) begin
                next_r.hvc_high_seen = 1'b0;
            end
            case (r.state)
                qp_st_idle: begin
                    if (accept && cmd_legal) begin
                        mem_bus.en = 1'b1;
                        next_r.pending_addr = cmd_addr;
                        next_r.pending_decrement = cmd_op == qp_op_decrement;
                        if (cmd_op == qp_op_write) begin
                            mem_bus.we = 1'b1;
                            if (qp_is_tcon(cmd_addr)) begin
                                mem_bus.wdata[qp_reserved_top_bit] = 1'b1; // [RULE11]
                            end
                        end else if (cmd_op == qp_op_read) begin
                            next_r.state = qp_st_read;
                        end else begin
                            next_r.state = qp_st_modify;
                        end
                    end
                end
                qp_st_read: begin
                    next_r.state = qp_st_idle;
                end
                qp_st_modify: begin
                    mem_bus.en = 1'b1;
                    mem_bus.we = 1'b1;
                    mem_bus.addr = r.pending_addr;
                    mem_bus.wdata = modified;
                    next_r.state = qp_st_idle;
                end
                default: begin
                    next_r.state = qp_st_idle;
                end
            endcase
            // terminals follow the stored value only once the serial command ends
            if (cmd_complete) begin
                next_r.applied[0] = mem_bus.words[qp_terminal_control_pots01_addr]; // [RULE8]
                next_r.applied[1] = mem_bus.words[qp_terminal_control_pots23_addr]; // [RULE8]
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= reset_state; // [RULE9] [RULE14]
        end else begin
            r <= next_r;
        end
    end

    assign rsp_valid = r.state == qp_st_read;
    assign rsp_data = mem_bus.rdata;
    assign error_active = r.error;

    always_comb begin
        wiper_position[0] = mem_bus.words[qp_wiper0_position_addr];
        wiper_position[1] = mem_bus.words[qp_wiper1_position_addr];
        wiper_position[2] = mem_bus.words[qp_wiper2_position_addr];
        wiper_position[3] = mem_bus.words[qp_wiper3_position_addr];
    end

    // pot 2k uses the lower nibble and pot 2k+1 the upper nibble of register k
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            pot_shutdown_forced[2*k] = ~r.applied[k][qp_lower_shutdown_release]; // [RULE12] [RULE6]
            pot_end_a_connect[2*k] = r.applied[k][qp_lower_end_a_connect]; // [RULE7]
            pot_wiper_connect[2*k] = r.applied[k][qp_lower_wiper_connect]; // [RULE7]
            pot_end_b_connect[2*k] = r.applied[k][qp_lower_end_b_connect]; // [RULE7]
            pot_shutdown_forced[2*k+1] = ~r.applied[k][qp_upper_shutdown_release]; // [RULE12] [RULE6]
            pot_end_a_connect[2*k+1] = r.applied[k][qp_upper_end_a_connect]; // [RULE7]
            pot_wiper_connect[2*k+1] = r.applied[k][qp_upper_wiper_connect]; // [RULE7]
            pot_end_b_connect[2*k+1] = r.applied[k][qp_upper_end_b_connect]; // [RULE7]
        end
    end

endmodule : qp_regmap

// *** sim/qp_regmap_properties.sv ***
// port checker for the quad pot register bank
`timescale 1ns/1ps
module qp_regmap_properties import qp_pkg::*; #(
    parameter logic wide_wiper = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic reset_pin_n,
    input wire qp_pkg::qp_hvc_type high_voltage_command_pin,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire qp_pkg::qp_op_type cmd_op,
    input wire qp_pkg::qp_addr_type cmd_addr,
    input wire logic cmd_complete,
    input wire logic rsp_valid,
    input wire logic error_active,
    input wire logic [3:0][8:0] wiper_position,
    input wire logic [3:0] pot_end_a_connect
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic taken;
    logic rd;
    logic step;
    assign taken = cmd_valid && cmd_ready;
    // reads of reserved addresses are refused with an error and get no answer
    assign rd = taken && cmd_op == qp_op_read && (qp_is_wiper(cmd_addr) || qp_is_tcon(cmd_addr));
    assign step = cmd_op inside {qp_op_increment, qp_op_decrement};
    AST_READ_ANSWER: assert property (rd |=> rsp_valid) else $error("read not answered");
    AST_ANSWER_CAUSE: assert property (rsp_valid |-> $past(rd)) else $error("stray answer");
    AST_RESERVED_ERROR: assert property (taken && !qp_is_wiper(cmd_addr) && !qp_is_tcon(cmd_addr)
        |=> error_active) else $error("reserved address accepted");
    AST_TCON_STEP_ERROR: assert property (taken && qp_is_tcon(cmd_addr) && step |=> error_active)
        else $error("step on terminal control accepted");
    AST_LEGAL_NO_ERROR: assert property (taken && (qp_is_wiper(cmd_addr) || qp_is_tcon(cmd_addr) && !step)
        |=> !error_active) else $error("legal command flagged");
    AST_ERROR_CLEAR_ORDER: assert property ($fell(error_active) && $past(reset_pin_n)
        |-> $past(high_voltage_command_pin, 2) == qp_hvc_normal_high) else $error("error cleared early");
    AST_ERROR_BLOCKS: assert property (error_active |-> !cmd_ready) else $error("ready in error");
    AST_PIN_RESET: assert property (!reset_pin_n |=> wiper_position[0] == qp_wiper_reset(wide_wiper)
        && pot_end_a_connect == 4'hf && !error_active) else $error("pin reset ignored");
    AST_PIN_BLOCKS: assert property (!reset_pin_n |-> !cmd_ready) else $error("port open in reset");
    AST_TERMINAL_HOLD: assert property (!$past(cmd_complete) && $past(reset_pin_n)
        |-> $stable(pot_end_a_connect)) else $error("terminal moved before completion");
    cover property (rd);
    cover property ($fell(error_active));
    cover property (cmd_complete);
endmodule : qp_regmap_properties

bind qp_regmap qp_regmap_properties #(.wide_wiper(wide_wiper)) u_props (.clk(clk), .reset(reset),
    .reset_pin_n(reset_pin_n), .high_voltage_command_pin(high_voltage_command_pin), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_complete(cmd_complete),
    .rsp_valid(rsp_valid), .error_active(error_active), .wiper_position(wiper_position),
    .pot_end_a_connect(pot_end_a_connect));

// *** sim/qp_host.sv ***
// host controller model: command port, completion pulse and command pin
`timescale 1ns/1ps
module qp_host import qp_pkg::*; (
    input wire logic clk,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire qp_pkg::qp_word_type rsp_data,
    output logic cmd_valid,
    output qp_pkg::qp_op_type cmd_op,
    output qp_pkg::qp_addr_type cmd_addr,
    output qp_pkg::qp_word_type cmd_wdata,
    output logic cmd_complete,
    output qp_pkg::qp_hvc_type high_voltage_command_pin
);
    int stalls = 0;
    initial begin
        cmd_valid = 1'b0;
        cmd_op = qp_op_read;
        cmd_addr = 4'h0;
        cmd_wdata = 9'h000;
        cmd_complete = 1'b0;
        high_voltage_command_pin = qp_hvc_low;
    end
    task automatic run(input qp_op_type op, input qp_addr_type a, input qp_word_type d, output qp_word_type q);
        int n;
        n = 0;
        q = 'x;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(negedge clk);
        while (!cmd_ready && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (!cmd_ready) stalls++;
        @(posedge clk);
        cmd_valid <= 1'b0;
        // released lines carry the inverse so stale data cannot pass as fresh
        cmd_addr <= ~a;
        cmd_wdata <= ~d;
        @(negedge clk);
        if (op == qp_op_read && rsp_valid === 1'b1) q = rsp_data;
    endtask : run
    task automatic complete_cmd();
        @(posedge clk);
        cmd_complete <= 1'b1;
        @(posedge clk);
        cmd_complete <= 1'b0;
    endtask : complete_cmd
    task automatic drive_pin(input qp_hvc_type v);
        @(posedge clk);
        high_voltage_command_pin <= v;
    endtask : drive_pin
endmodule : qp_host

// *** sim/qp_regmap_bench.sv ***
// self-checking bench for the quad pot register bank
`timescale 1ns/1ps
module qp_regmap_bench;
    import qp_pkg::*;
    typedef struct packed {qp_op_type op; qp_addr_type addr; qp_word_type wdata; qp_word_type exp;} qp_row_type;
    localparam qp_op_type rd = qp_op_read;
    localparam qp_op_type wr = qp_op_write;
    localparam qp_op_type up = qp_op_increment;
    localparam qp_op_type dn = qp_op_decrement;
    localparam qp_row_type rows [19] = '{'{rd, 4'h0, 9'h0, 9'h080}, '{rd, 4'h7, 9'h0, 9'h080},
        '{rd, 4'h4, 9'h0, 9'h1ff}, '{rd, 4'ha, 9'h0, 9'h1ff}, '{wr, 4'h1, 9'h0ff, 9'h0}, '{rd, 4'h1, 9'h0, 9'h0ff},
        '{up, 4'h1, 9'h0, 9'h0}, '{rd, 4'h1, 9'h0, 9'h100}, '{up, 4'h1, 9'h0, 9'h0}, '{rd, 4'h1, 9'h0, 9'h100},
        '{dn, 4'h6, 9'h0, 9'h0}, '{rd, 4'h6, 9'h0, 9'h07f}, '{wr, 4'h0, 9'h000, 9'h0}, '{dn, 4'h0, 9'h0, 9'h0},
        '{rd, 4'h0, 9'h0, 9'h000}, '{wr, 4'h4, 9'h0a5, 9'h0}, '{rd, 4'h4, 9'h0, 9'h1a5}, '{wr, 4'ha, 9'h05a, 9'h0},
        '{rd, 4'ha, 9'h0, 9'h15a}};
    localparam qp_row_type errs [6] = '{'{rd, 4'h2, 9'h0, 9'h0}, '{wr, 4'h5, 9'h0, 9'h0},
        '{up, 4'h8, 9'h0, 9'h0}, '{dn, 4'hf, 9'h0, 9'h0}, '{up, 4'h4, 9'h0, 9'h0}, '{dn, 4'ha, 9'h0, 9'h0}};
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic reset_pin_n = 1'b1;
    logic cmd_valid, cmd_ready, cmd_complete, rsp_valid, error_active;
    qp_op_type cmd_op;
    qp_addr_type cmd_addr;
    qp_word_type cmd_wdata, rsp_data, q;
    qp_hvc_type pin;
    logic [3:0][8:0] wiper_position;
    logic [3:0][8:0] wiper7;
    logic [3:0] pot_shutdown_forced, pot_end_a_connect, pot_wiper_connect, pot_end_b_connect;
    int n_mismatch = 0;
    int tests_run = 0;
    always #5 clk = ~clk;
    qp_regmap uut (.clk(clk), .reset(reset), .reset_pin_n(reset_pin_n), .high_voltage_command_pin(pin),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_complete(cmd_complete), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .error_active(error_active), .wiper_position(wiper_position), .pot_shutdown_forced(pot_shutdown_forced),
        .pot_end_a_connect(pot_end_a_connect), .pot_wiper_connect(pot_wiper_connect),
        .pot_end_b_connect(pot_end_b_connect));
    qp_host host (.clk(clk), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_complete(cmd_complete), .high_voltage_command_pin(pin));
    // 7-bit variant follows the same command stream; only its wiper values are watched
    qp_regmap #(.wide_wiper(1'b0)) uut_narrow (.clk(clk), .reset(reset), .reset_pin_n(reset_pin_n),
        .high_voltage_command_pin(pin), .cmd_valid(cmd_valid), .cmd_ready(), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_complete(cmd_complete), .rsp_valid(), .rsp_data(), .error_active(),
        .wiper_position(wiper7), .pot_shutdown_forced(), .pot_end_a_connect(), .pot_wiper_connect(),
        .pot_end_b_connect());
    task automatic chk(input qp_word_type got, input qp_word_type exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp);
        chk({5'h00, got}, {5'h00, exp});
    endtask : chk_bits
    task automatic clear_error(input qp_hvc_type act);
        host.drive_pin(qp_hvc_normal_high);
        repeat (2) @(negedge clk);
        chk_bits({3'h0, error_active}, 4'h1);
        host.drive_pin(act);
        repeat (2) @(negedge clk);
        chk_bits({3'h0, error_active}, 4'h0);
    endtask : clear_error
    task automatic print_verdict();
        n_mismatch += host.stalls;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            host.run(rows[i].op, rows[i].addr, rows[i].wdata, q);
            if (rows[i].op == rd) chk(q, rows[i].exp);
        end
        chk(wiper_position[2], 9'h07f);
        chk(wiper7[2], 9'h03f);
        chk(wiper7[3], 9'h040);
        chk_bits(pot_end_a_connect, 4'hf);
        host.complete_cmd();
        @(negedge clk);
        chk_bits(pot_end_a_connect, 4'h9);
        chk_bits(pot_wiper_connect, 4'h6);
        chk_bits(pot_end_b_connect, 4'h9);
        chk_bits(pot_shutdown_forced, 4'h9);
        foreach (errs[i]) begin
            host.run(errs[i].op, errs[i].addr, 9'h000, q);
            chk_bits({3'h0, error_active}, 4'h1);
            clear_error(i[0] ? qp_hvc_high_voltage : qp_hvc_low);
        end
        @(posedge clk) reset_pin_n <= 1'b0;
        @(negedge clk) chk_bits({3'h0, cmd_ready}, 4'h0);
        @(posedge clk) reset_pin_n <= 1'b1;
        @(negedge clk) chk(wiper_position[0], 9'h080);
        chk(wiper7[0], 9'h040);
        chk_bits(pot_shutdown_forced, 4'h0);
        host.run(wr, 4'h4, 9'h077, q);
        host.complete_cmd();
        @(negedge clk) chk_bits(pot_shutdown_forced, 4'h3);
        @(posedge clk) reset <= 1'b1;
        @(posedge clk) reset <= 1'b0;
        host.run(rd, 4'h4, 9'h000, q);
        chk(q, 9'h1ff);
        chk_bits(pot_shutdown_forced, 4'h0);
        print_verdict();
    end
endmodule : qp_regmap_bench
